// ---- common/iox_defines.vh ----
`ifndef IOX_DEFINES_VH
`define IOX_DEFINES_VH

// Fixed upper six bits of the 7-bit slave address
`define IOX_ADDR_BASE    6'h11

// Reset values
`define IOX_CMD_RESET    8'h00
`define IOX_OUT_RESET    8'hff
`define IOX_POL_RESET    8'h00
`define IOX_CFG_RESET    8'hff

// Command pointer fields
`define IOX_AI_BIT       7
`define IOX_GRP_HI       3
`define IOX_GRP_LO       2
`define IOX_BANK_HI      1
`define IOX_BANK_LO      0

// Register groups and the reserved bank code
`define IOX_GRP_IN       2'h0
`define IOX_GRP_OUT      2'h1
`define IOX_GRP_POL      2'h2
`define IOX_GRP_CFG      2'h3
`define IOX_BANK_RSV     2'h3
`define IOX_BANK_LAST    2'h2

// Byte framing
`define IOX_BITS_BYTE    4'h8
`define IOX_BIT_FIRST    4'h1

// Which byte of a transfer is being received
`define IOX_PH_ADDR      2'h0
`define IOX_PH_CMD       2'h1
`define IOX_PH_DATA      2'h2

`endif

// ---- src/iox_regs.v ----
`include "iox_defines.vh"

module iox_regs #(
   parameter BANKS = 3
) (
   // Clock and reset
   input  wire               core_clk,
   input  wire               rst_b,
   // Write strobe with selection and data
   input  wire               wr_en,
   input  wire [1:0]         wr_grp,
   input  wire [1:0]         wr_bank,
   input  wire [7:0]         wr_data,
   // Read selection and current pin levels
   input  wire [1:0]         rd_grp,
   input  wire [1:0]         rd_bank,
   input  wire [8*BANKS-1:0] pins,
   // Register contents
   output wire [8*BANKS-1:0] out_bits,
   output wire [8*BANKS-1:0] pol_bits,
   output wire [8*BANKS-1:0] cfg_bits,
   output reg  [7:0]         rd_data_q
);

   reg  [8*BANKS-1:0] out_q;
   reg  [8*BANKS-1:0] pol_q;
   reg  [8*BANKS-1:0] cfg_q;
   reg  [7:0]         rd_d;
   wire [4:0]         rd_base;

   assign rd_base  = {rd_bank, 3'h0};
   assign out_bits = out_q;
   assign pol_bits = pol_q;
   assign cfg_bits = cfg_q;

   genvar b;
   generate
      for (b = 0; b < BANKS; b = b + 1) begin : g_bank
         localparam [1:0] BK = b;
         always @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               out_q[8*b+7:8*b] <= `IOX_OUT_RESET; // R3
               pol_q[8*b+7:8*b] <= `IOX_POL_RESET; // R3
               cfg_q[8*b+7:8*b] <= `IOX_CFG_RESET; // R3
            end else if (wr_en && wr_bank == BK) begin
               // Input group is read-only; writes there are dropped
               case (wr_grp)
                  `IOX_GRP_OUT: out_q[8*b+7:8*b] <= wr_data; // R24
                  `IOX_GRP_POL: pol_q[8*b+7:8*b] <= wr_data; // R24
                  `IOX_GRP_CFG: cfg_q[8*b+7:8*b] <= wr_data; // R24
                  default: ;
               endcase
            end
         end
      end
   endgenerate

   // Reserved bank codes read back as zero
   always @* begin
      rd_d = 8'h00;
      if (rd_bank != `IOX_BANK_RSV) begin
         case (rd_grp)
            `IOX_GRP_IN:  rd_d = pins[rd_base +: 8] ^ pol_q[rd_base +: 8];
            `IOX_GRP_OUT: rd_d = out_q[rd_base +: 8];
            `IOX_GRP_POL: rd_d = pol_q[rd_base +: 8];
            default:      rd_d = cfg_q[rd_base +: 8];
         endcase
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rd_d;
      end
   end

endmodule

// ---- src/iox_sync.v ----
module iox_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         core_clk,
   input  wire         rst_b,
   // Asynchronous levels in, synchronised levels out
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_q[i] <= 1'b1;
               sync_q[i] <= 1'b1;
            end else begin
               meta_q[i] <= async_in[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign sync_out = sync_q;

endmodule

// ---- src/iox_top.v ----
`include "iox_defines.vh"

// Notes on behaviour
// R1 - Pin set as input: both drivers off, pin high impedance.
// R2 - Pin set as output: one driver on, level from output latch bit.
// R3 - Reset returns every register to default; all pins become inputs.
// R4 - Reset input low initialises registers and bus state machine alike.
// R5 - Master starts a transfer on an idle bus with SDA falling, SCL high.
// R6 - Master ends a transfer with SDA rising while SCL high.
// R7 - Address byte arrives MSB first, direction bit last.
// R8 - Matching address acknowledged by SDA low through ninth clock high.
// R9 - Address select input stays constant from start to stop.
// R10 - SDA changes only with SCL low; changes at SCL high are start/stop.
// R11 - Bytes are eight data bits plus one acknowledge from receiver.
// R12 - Device acknowledges every byte it receives as a receiver.
// R13 - Master acknowledges every read byte except the last.
// R14 - Master leaves last read byte unacknowledged; device releases SDA.
// R15 - Address is 010001 then the address select level: 22h or 23h.
// R16 - Direction bit 1 means read, 0 means write.
// R17 - First written byte after address goes to the command pointer.
// R18 - Reads use pointer from last command byte; commands only in writes.
// R19 - Pointer top bit enables auto-increment.
// R20 - Command pointer resets to 00h.
// R21 - Auto-increment cycles banks 0,1,2 skipping reserved code, wraps.
// R22 - Without auto-increment every data byte uses the same bank.
// R23 - Master never sends reserved or undefined command codes.
// R24 - Groups: input 00-02, output 04-06, polarity 08-0A, direction 0C-0E.
// R25 - Interrupt active while any pin differs from its input register.
// R26 - Unmatched address: SDA released, transfer ignored until next start.
module iox_top #(
   parameter BANKS = 3
) (
   // Clock and reset
   input  wire               core_clk,
   input  wire               rst_b,
   // Serial bus
   input  wire               scl_in,
   input  wire               sda_in,
   output reg                sda_out_q,
   output reg                sda_oe_q,
   // Address select strap
   input  wire               addr_sel,
   // Port pins
   input  wire [8*BANKS-1:0] port_in,
   output reg  [8*BANKS-1:0] port_out_q,
   output reg  [8*BANKS-1:0] port_oe_q,
   // Open-drain interrupt, active low
   output reg                int_out_q,
   output reg                int_oe_q
);

   localparam W = 8 * BANKS;

   // One-hot states
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RX   = 5'h02;
   localparam [4:0] ST_RACK = 5'h04;
   localparam [4:0] ST_TX   = 5'h08;
   localparam [4:0] ST_TACK = 5'h10;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   wire [W+2:0] sync_v;
   wire         scl_s;
   wire         sda_s;
   wire         addr_s;
   wire [W-1:0] pins_s;

   iox_sync #(
      .W (W + 3)
   ) u_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .async_in ({scl_in, sda_in, addr_sel, port_in}),
      .sync_out (sync_v)
   );

   assign scl_s  = sync_v[W+2];
   assign sda_s  = sync_v[W+1];
   assign addr_s = sync_v[W];
   assign pins_s = sync_v[W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Start-up: the input register waits until the synchronisers hold
   // real pin levels, otherwise their idle ones would raise the interrupt

   reg  [2:0]   init_q;
   wire         init_load;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         init_q <= 3'h7;
      end else begin
         init_q <= {init_q[1:0], 1'b0};
      end
   end

   // High for the one cycle before the third edge after release
   assign init_load = init_q[2] & ~init_q[1];

   ////////////////////////////////////////////////////////////////////////
   // Bus event detection

   reg  scl_p_q;
   reg  sda_p_q;
   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;
   // SDA moving while SCL stays high is a framing event, never data
   assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s; // R10 R5
   assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s; // R10 R6

   ////////////////////////////////////////////////////////////////////////
   // Register file

   reg  [7:0]   ptr_q;
   reg          wr_en_q;
   reg  [3:0]   wr_sel_q;
   reg  [7:0]   wr_data_q;
   wire [W-1:0] out_bits;
   wire [W-1:0] pol_bits;
   wire [W-1:0] cfg_bits;
   wire [7:0]   rd_data;

   iox_regs #(
      .BANKS (BANKS)
   ) u_regs (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .wr_en     (wr_en_q),
      .wr_grp    (wr_sel_q[3:2]),
      .wr_bank   (wr_sel_q[1:0]),
      .wr_data   (wr_data_q),
      .rd_grp    (ptr_q[`IOX_GRP_HI:`IOX_GRP_LO]),
      .rd_bank   (ptr_q[`IOX_BANK_HI:`IOX_BANK_LO]),
      .pins      (pins_s),
      .out_bits  (out_bits),
      .pol_bits  (pol_bits),
      .cfg_bits  (cfg_bits),
      .rd_data_q (rd_data)
   );

   // Next pointer value after a data byte
   function [7:0] ptr_step;
      input [7:0] p;
      begin
         ptr_step = p;
         if (p[`IOX_AI_BIT]) begin // R19
            if (p[1:0] >= `IOX_BANK_LAST) begin
               ptr_step[1:0] = 2'h0; // R21
            end else begin
               ptr_step[1:0] = p[1:0] + 2'h1; // R21
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Serial state machine

   reg  [4:0]   state_q;
   reg  [3:0]   bit_q;
   reg  [7:0]   sr_q;
   reg  [1:0]   phase_q;
   reg          rw_q;
   reg  [W-1:0] in_latch_q;
   wire         addr_hit;
   wire         rd_in_grp;
   wire         rd_load;

   // Address is the fixed six bits followed by the strap level
   assign addr_hit  = (sr_q[7:1] == {`IOX_ADDR_BASE, addr_s}); // R15 R9
   assign rd_in_grp = (ptr_q[`IOX_GRP_HI:`IOX_GRP_LO] == `IOX_GRP_IN) &&
                      (ptr_q[1:0] != `IOX_BANK_RSV);

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= ST_IDLE; // R4
         bit_q      <= 4'h0;
         sr_q       <= 8'h00;
         phase_q    <= `IOX_PH_ADDR;
         rw_q       <= 1'b0;
         ptr_q      <= `IOX_CMD_RESET; // R20 R3
         wr_en_q    <= 1'b0;
         wr_sel_q   <= 4'h0;
         wr_data_q  <= 8'h00;
         sda_out_q  <= 1'b0;
         sda_oe_q   <= 1'b0;
      end else begin
         wr_en_q <= 1'b0;
         if (bus_start) begin
            state_q  <= ST_RX;
            phase_q  <= `IOX_PH_ADDR;
            bit_q    <= 4'h0;
            sda_oe_q <= 1'b0;
         end else if (bus_stop) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  sda_oe_q <= 1'b0; // R26
               end
               ST_RX: begin
                  if (scl_rise && bit_q < `IOX_BITS_BYTE) begin
                     sr_q  <= {sr_q[6:0], sda_s}; // R7 R11
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == `IOX_BITS_BYTE) begin
                     bit_q <= 4'h0;
                     case (phase_q)
                        `IOX_PH_ADDR: begin
                           if (addr_hit) begin
                              rw_q     <= sr_q[0]; // R16
                              sda_oe_q <= 1'b1; // R8
                              state_q  <= ST_RACK;
                              phase_q  <= `IOX_PH_CMD;
                           end else begin
                              state_q <= ST_IDLE; // R26
                           end
                        end
                        `IOX_PH_CMD: begin
                           ptr_q    <= sr_q; // R17 R18
                           sda_oe_q <= 1'b1; // R12
                           state_q  <= ST_RACK;
                           phase_q  <= `IOX_PH_DATA;
                        end
                        default: begin
                           wr_en_q   <= 1'b1;
                           wr_sel_q  <= ptr_q[3:0]; // R24
                           wr_data_q <= sr_q;
                           ptr_q     <= ptr_step(ptr_q); // R21 R22
                           sda_oe_q  <= 1'b1; // R12
                           state_q   <= ST_RACK;
                        end
                     endcase
                  end
               end
               ST_RACK: begin
                  // Acknowledge held low until SCL falls after the ninth pulse
                  if (scl_fall) begin
                     if (rw_q) begin
                        // Read reuses the pointer left by the last command
                        sda_oe_q <= ~rd_data[7]; // R18
                        sr_q     <= {rd_data[6:0], 1'b0};
                        bit_q    <= `IOX_BIT_FIRST;
                        ptr_q    <= ptr_step(ptr_q); // R21 R22
                        state_q  <= ST_TX;
                     end else begin
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_q == `IOX_BITS_BYTE) begin
                        sda_oe_q <= 1'b0; // R11
                        state_q  <= ST_TACK;
                     end else begin
                        sda_oe_q <= ~sr_q[7]; // R10
                        sr_q     <= {sr_q[6:0], 1'b0};
                        bit_q    <= bit_q + 4'h1;
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise && sda_s) begin
                     // Not acknowledged: last byte, leave SDA to the master
                     sda_oe_q <= 1'b0; // R14 R13
                     state_q  <= ST_IDLE;
                  end else if (scl_fall) begin
                     sda_oe_q <= ~rd_data[7];
                     sr_q     <= {rd_data[6:0], 1'b0};
                     bit_q    <= `IOX_BIT_FIRST;
                     ptr_q    <= ptr_step(ptr_q); // R21 R22
                     state_q  <= ST_TX;
                  end
               end
               default: begin
                  state_q  <= ST_IDLE;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input register, one latch per bank

   // A bank takes the pins when it is loaded for reading or at start-up
   assign rd_load = scl_fall && rd_in_grp &&
                    ((state_q == ST_RACK && rw_q) || state_q == ST_TACK);

   genvar g;
   generate
      for (g = 0; g < BANKS; g = g + 1) begin : g_latch
         localparam [1:0] BK = g;
         always @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               in_latch_q[8*g+7:8*g] <= 8'h00;
            end else if (init_load) begin
               in_latch_q[8*g+7:8*g] <= pins_s[8*g+7:8*g];
            end else if (rd_load && ptr_q[1:0] == BK) begin // R25
               in_latch_q[8*g+7:8*g] <= pins_s[8*g+7:8*g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Port drivers and interrupt

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_out_q <= {W{1'b1}};
         port_oe_q  <= {W{1'b0}}; // R3 R1
         int_out_q  <= 1'b0;
         int_oe_q   <= 1'b0;
      end else begin
         // Direction bit 1 is input: both drivers off
         port_oe_q  <= ~cfg_bits; // R1 R2
         port_out_q <= out_bits; // R2
         // Lags the pins by the synchroniser; reading the input banks that changed clears it
         int_oe_q   <= (pins_s != in_latch_q) && !init_q[2]; // R25
      end
   end

endmodule

// ---- verif/iox_master.sv ----
module iox_master (
   // Bus lines
   output logic scl,
   output logic sda_low,
   input  wire  sda
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle bus: clock high, data released to the pull-up
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One bit: data moves only in the low phase, sampled mid high phase
   task automatic bit_x(input logic b, output logic r);
      #10 sda_low = ~b;
      #30 scl = 1'b1;
      #20 r = sda;
      #20 scl = 1'b0;
   endtask

   task automatic start_c;
      sda_low = 1'b0;
      scl     = 1'b1;
      #40 sda_low = 1'b1;
      #40 scl = 1'b0;
   endtask

   task automatic stop_c;
      #10 sda_low = 1'b1;
      #30 scl = 1'b1;
      #40 sda_low = 1'b0;
      #40;
   endtask

   // Releases the line in the ninth slot so the receiver can answer
   task automatic send(input logic [7:0] b, output logic ack);
      logic   r;
      integer i;
      for (i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   task automatic recv(input logic last, output logic [7:0] b);
      logic   r;
      integer i;
      for (i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         b[i] = r;
      end
      bit_x(last, r);
   endtask
endmodule

// ---- verif/iox_top_asserts.sv ----
module iox_top_asserts #(
   parameter BANKS = 3
) (
   // Clock and reset
   input wire               core_clk,
   input wire               rst_b,
   // Serial bus
   input wire               scl_in,
   input wire               sda_in,
   input wire               sda_out_q,
   input wire               sda_oe_q,
   // Strap and port pins
   input wire               addr_sel,
   input wire [8*BANKS-1:0] port_in,
   input wire [8*BANKS-1:0] port_out_q,
   input wire [8*BANKS-1:0] port_oe_q,
   // Interrupt
   input wire               int_out_q,
   input wire               int_oe_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_reset_vals;
      $rose(rst_b) |-> port_oe_q == '0 && (&port_out_q) && !sda_oe_q;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("reset values wrong");
   property p_sda_drv;
      sda_out_q == 1'b0;
   endproperty
   a_sda_drv: assert property (p_sda_drv)
      else $error("data pin drives high");
   property p_int_drv;
      int_out_q == 1'b0;
   endproperty
   a_int_drv: assert property (p_int_drv)
      else $error("interrupt pin drives high");
   // Synchroniser lag: a legal change sits inside the clock low phase
   property p_oe_scl_low;
      $changed(sda_oe_q) |-> $past(!scl_in, 2);
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("data pin moved with clock high");
   property p_ack_hold;
      $rose(sda_oe_q) |-> sda_oe_q [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("low drive not held through high phase");
   property p_rel_hold;
      $fell(sda_oe_q) |-> !sda_oe_q [*4];
   endproperty
   a_rel_hold: assert property (p_rel_hold)
      else $error("release glitch on data pin");
   property p_idle_stable;
      scl_in [*8] |-> $stable(sda_oe_q);
   endproperty
   a_idle_stable: assert property (p_idle_stable)
      else $error("data pin moved during long clock high");
   property p_cfg_timing;
      $changed(port_oe_q) |-> $past(!scl_in, 4);
   endproperty
   a_cfg_timing: assert property (p_cfg_timing)
      else $error("direction changed outside a byte end");
   property p_out_timing;
      $changed(port_out_q) |-> $past(!scl_in, 4);
   endproperty
   a_out_timing: assert property (p_out_timing)
      else $error("output latch changed outside a byte end");
   property p_int_init;
      $rose(rst_b) |-> !int_oe_q [*4];
   endproperty
   a_int_init: assert property (p_int_init)
      else $error("interrupt raised while starting up");
   c_ack: cover property ($rose(sda_oe_q));
endmodule

bind iox_top iox_top_asserts #(.BANKS(BANKS)) i_chk (
   .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .addr_sel(addr_sel),
   .port_in(port_in), .port_out_q(port_out_q), .port_oe_q(port_oe_q),
   .int_out_q(int_out_q), .int_oe_q(int_oe_q));

// ---- verif/iox_top_test.sv ----
module iox_top_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic        core_clk, rst_b, addr_sel, ack;
   logic [23:0] port_in, ex_out, pol_v;
   logic [7:0]  b;
   logic [7:0]  d [0:3];
   wire         scl, sda, m_low, sda_out_q, sda_oe_q, int_out_q, int_oe_q;
   wire  [23:0] port_out_q, port_oe_q;
   integer      errors, tests_run, i;

   // Pull-up on the data line, wired low by either party
   assign sda = !(m_low || (sda_oe_q && !sda_out_q));

   iox_master i_master (.scl(scl), .sda_low(m_low), .sda(sda));
   iox_top #(.BANKS(3)) i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
      .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .addr_sel(addr_sel),
      .port_in(port_in), .port_out_q(port_out_q), .port_oe_q(port_oe_q),
      .int_out_q(int_out_q), .int_oe_q(int_oe_q));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] addr_byte(input logic sel, input logic rd);
      return {6'h11, sel, rd};
   endfunction

   task automatic chk_vec(input string nm, input logic [23:0] e, g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Command byte then n data bytes from d, all acknowledged
   task automatic xfer_w(input logic [7:0] cmd, input integer n);
      integer k;
      i_master.start_c();
      i_master.send(addr_byte(1'b0, 1'b0), ack);
      chk_bit("addr_ack", 1'b1, ack);
      i_master.send(cmd, ack);
      chk_bit("cmd_ack", 1'b1, ack);
      for (k = 0; k < n; k++) begin
         i_master.send(d[k], ack);
         chk_bit("data_ack", 1'b1, ack);
      end
      i_master.stop_c();
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Whole run is well under 60 us of bus traffic
   initial begin
      #200000;
      errors++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      errors = 0;
      tests_run = 0;
      rst_b = 1'b0;
      addr_sel = 1'b0;
      port_in = 24'h000000;
      void'($urandom(52));
      repeat (12) @(posedge core_clk);
      #1 rst_b = 1'b1;
      repeat (6) @(posedge core_clk);
      chk_vec("port_oe", 24'h000000, port_oe_q);
      chk_vec("port_out", 24'hffffff, port_out_q);
      chk_bit("int_rst", 1'b0, int_oe_q);
      $display("test reset done");
      #1 i_master.start_c();
      i_master.send(addr_byte(1'b1, 1'b0), ack);
      chk_bit("other_addr", 1'b0, ack);
      i_master.send(8'h84, ack);
      chk_bit("ignored_byte", 1'b0, ack);
      i_master.stop_c();
      chk_vec("port_out", 24'hffffff, port_out_q);
      $display("test foreign address done");
      for (i = 0; i < 4; i++) d[i] = 8'($urandom);
      xfer_w(8'h84, 4);
      ex_out = {d[2], d[1], d[3]};
      chk_vec("out_ai", ex_out, port_out_q);
      for (i = 0; i < 3; i++) d[i] = 8'($urandom);
      xfer_w(8'h8c, 3);
      chk_vec("dir_ai", ~{d[2], d[1], d[0]}, port_oe_q);
      $display("test auto increment done");
      for (i = 0; i < 2; i++) d[i] = 8'($urandom);
      xfer_w(8'h05, 2);
      ex_out[15:8] = d[1];
      chk_vec("out_same", ex_out, port_out_q);
      for (i = 0; i < 3; i++) d[i] = 8'($urandom);
      xfer_w(8'h88, 3);
      pol_v = {d[2], d[1], d[0]};
      $display("test fixed bank done");
      @(posedge core_clk);
      #1 port_in = 24'($urandom);
      xfer_w(8'h80, 0);
      i_master.start_c();
      i_master.send(addr_byte(1'b0, 1'b1), ack);
      chk_bit("rd_ack", 1'b1, ack);
      for (i = 0; i < 3; i++) begin
         i_master.recv(i == 2, b);
         ex_out = {16'h0, port_in[8*i +: 8] ^ pol_v[8*i +: 8]};
         chk_vec("rd_data", ex_out, {16'h0, b});
      end
      i_master.stop_c();
      chk_bit("released", 1'b0, sda_oe_q);
      chk_bit("int_quiet", 1'b0, int_oe_q);
      @(posedge core_clk);
      #1 port_in = ~port_in;
      repeat (6) @(posedge core_clk);
      chk_bit("int_active", 1'b1, int_oe_q);
      $display("test read done");
      @(posedge core_clk);
      #1 addr_sel = 1'b1;
      repeat (6) @(posedge core_clk);
      #1 i_master.start_c();
      i_master.send(addr_byte(1'b1, 1'b0), ack);
      chk_bit("addr_hi_ack", 1'b1, ack);
      i_master.stop_c();
      $display("test strap done");
      @(posedge core_clk);
      #1 rst_b = 1'b0;
      repeat (3) @(posedge core_clk);
      chk_vec("rst_oe", 24'h000000, port_oe_q);
      chk_vec("rst_out", 24'hffffff, port_out_q);
      #1 rst_b = 1'b1;
      repeat (6) @(posedge core_clk);
      chk_bit("rst_int", 1'b0, int_oe_q);
      // Pointer is back at 00h: input bank 0, no auto-increment
      #1 i_master.start_c();
      i_master.send(addr_byte(1'b1, 1'b1), ack);
      chk_bit("rst_rd_ack", 1'b1, ack);
      i_master.recv(1'b1, b);
      chk_vec("rst_ptr", {16'h0, port_in[7:0]}, {16'h0, b});
      i_master.stop_c();
      $display("test mid reset done");
      give_verdict();
   end
endmodule
